// ==== fpeg_pkg.sv ====
// Package: register map, key codes, timing and carrier types of the flash guard
package fpeg_pkg;
  // Register offsets on the core's special-register bus
  localparam logic [7:0] FPEG_BANK_OFS = 8'h84;
  localparam logic [7:0] FPEG_CTRL_OFS = 8'h8F;
  localparam logic [7:0] FPEG_TIME_OFS = 8'hB6;
  localparam logic [7:0] FPEG_KEY_OFS = 8'hB7;
  localparam logic [7:0] FPEG_DUMMY_OFS = 8'hE5;
  // Field positions
  localparam int FPEG_WE_BIT = 0;
  localparam int FPEG_EE_BIT = 1;
  localparam int FPEG_BYPASS_BIT = 6;
  localparam int FPEG_BANK_LSB = 0;
  // Reset values
  localparam logic [1:0] FPEG_BANK_RST = 2'h0;
  localparam logic FPEG_CTRL_RST = 1'b0;
  localparam logic FPEG_BYPASS_RST = 1'b0;
  // Key codes, in the order they must arrive
  localparam logic [7:0] FPEG_KEY1 = 8'hA5;
  localparam logic [7:0] FPEG_KEY2 = 8'hF1;
  // Erased byte value and page size
  localparam logic [7:0] FPEG_ERASED = 8'hFF;
  localparam int FPEG_PAGE_BITS = 10;
  // Timing: clock period and self-timed operation lengths
  localparam int FPEG_CLK_NS = 20;
  localparam int FPEG_WRITE_NS = 40000;
  localparam int FPEG_ERASE_NS = 20000000;
  localparam int FPEG_WRITE_CYC = (FPEG_WRITE_NS + FPEG_CLK_NS - 1) / FPEG_CLK_NS;
  localparam int FPEG_ERASE_CYC = (FPEG_ERASE_NS + FPEG_CLK_NS - 1) / FPEG_CLK_NS;
  // Key sequencer and operation states
  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_DEAD} fpeg_key_type;
  typedef enum logic [1:0] {OP_IDLE, OP_FETCH, OP_PROG, OP_ERASE} fpeg_op_type;
  // Special-register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpeg_sfr_type;
  // External-data write cycle from the core
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fpeg_xwr_type;
endpackage

// ==== fpeg_guard.sv ====
// Flash program/erase guard: enables, lock-and-key, self-timed stall, read timing
//
// Functional notes
// - Write enable routes external writes to flash
// - Byte write only clears bits; erase gives 0xFF
// - Operations self-timed; core stalled until done
// - Write enable stays set until software clears
// - Key codes 0xA5 then 0xF1 before each operation
// - Wrong or misordered key locks out until reset
// - Operation before full key also locks out
// - Lock re-engages after every write or erase
// - Supply monitor not ready gives flash-error reset
// - Erase clears whole 1024-byte page
// - Erase: enables, keys, one write in page
// - Bypass bit picks one-shot or clock read timing
// - Clearing bypass acts with no extra instruction
// - Dummy register accepts any write harmlessly
`timescale 1ns/10ps
module fpeg_guard
  import fpeg_pkg::*;
#(
  parameter int ERASE_CYCLES = FPEG_ERASE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire fpeg_sfr_type sfr,
  output logic [7:0] sfr_rdata,
  input wire fpeg_xwr_type xwr,
  input wire logic vdd_mon_on,
  input wire logic vdd_mon_reset_src,
  input wire logic [7:0] flash_rdata,
  output logic flash_prog,
  output logic flash_erase,
  output logic [16:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic cpu_stall,
  output logic flash_err_rst,
  output logic oneshot_bypass
);

  // Cycle counts of the self-timed operations
  localparam logic [19:0] WR_CNT = 20'(FPEG_WRITE_CYC - 1);
  localparam logic [19:0] ER_CNT = 20'(ERASE_CYCLES - 1);

  // Control registers
  logic we_q, we_d; // Store write enable
  logic ee_q, ee_d; // Store erase enable
  logic [1:0] bank_q, bank_d; // Code bank field
  logic bypass_q, bypass_d; // Read-timing one-shot bypass

  // Key sequencer
  fpeg_key_type key_q, key_d;

  // Operation engine
  fpeg_op_type op_q, op_d;
  logic [19:0] cnt_q, cnt_d; // Remaining cycles of the running operation
  logic [16:0] addr_q, addr_d; // Flash byte address
  logic [7:0] data_q, data_d; // Data of the pending byte write
  logic [7:0] wdata_q, wdata_d; // Data presented to the array
  logic [7:0] old_q, old_d; // Byte content before programming
  logic prog_q, prog_d; // Program strobe
  logic erase_q, erase_d; // Erase strobe
  logic err_q, err_d; // Flash-error reset pulse
  logic [7:0] rdata_q, rdata_d; // Read data

  // Decoded events
  logic key_wr; // Write to the key register
  logic attempt; // External write while write enable is set
  logic mon_ok; // Supply monitor on and acting as a reset source
  logic start; // Accepted flash operation
  logic [16:0] eff_addr; // Bank-mapped address of the external write

  // Event decode
  always_comb begin
    key_wr = sfr.wr && (sfr.addr == FPEG_KEY_OFS);
    attempt = xwr.valid && we_q && (op_q == OP_IDLE);
    mon_ok = vdd_mon_on && vdd_mon_reset_src;
    start = attempt && mon_ok && (key_q == KEY_OPEN);
    // Upper half of the code space is windowed by the bank field
    if (xwr.addr[15]) begin
      eff_addr = {bank_q, xwr.addr[14:0]};
    end else begin
      eff_addr = {2'h0, xwr.addr[14:0]};
    end
  end

  // Control register next values
  always_comb begin
    we_d = we_q;
    ee_d = ee_q;
    bank_d = bank_q;
    bypass_d = bypass_q;
    if (sfr.wr) begin
      unique case (sfr.addr)
        FPEG_CTRL_OFS: begin
          // Only software changes the enables; operations leave them alone
          we_d = sfr.wdata[FPEG_WE_BIT];
          ee_d = sfr.wdata[FPEG_EE_BIT];
        end
        FPEG_BANK_OFS: begin
          bank_d = sfr.wdata[FPEG_BANK_LSB +: 2];
        end
        FPEG_TIME_OFS: begin
          // Reserved bits are dropped; the new timing applies next cycle
          bypass_d = sfr.wdata[FPEG_BYPASS_BIT];
        end
        default: begin
          // Dummy register and others: the write has no effect here
        end
      endcase
    end
  end

  // Control register storage
  always_ff @(posedge clk) begin
    if (rst) begin
      we_q <= FPEG_CTRL_RST;
      ee_q <= FPEG_CTRL_RST;
      bank_q <= FPEG_BANK_RST;
      bypass_q <= FPEG_BYPASS_RST;
    end else begin
      we_q <= we_d;
      ee_q <= ee_d;
      bank_q <= bank_d;
      bypass_q <= bypass_d;
    end
  end

  // Key sequencer next state
  always_comb begin
    key_d = key_q;
    if (attempt && mon_ok) begin
      if (key_q == KEY_OPEN) begin
        key_d = KEY_LOCKED;
      end else begin
        key_d = KEY_DEAD;
      end
    end else if (key_wr) begin
      unique case (key_q)
        KEY_LOCKED: begin
          key_d = (sfr.wdata == FPEG_KEY1) ? KEY_HALF : KEY_DEAD;
        end
        KEY_HALF: begin
          key_d = (sfr.wdata == FPEG_KEY2) ? KEY_OPEN : KEY_DEAD;
        end
        KEY_OPEN: begin
          key_d = KEY_DEAD;
        end
        KEY_DEAD: begin
          key_d = KEY_DEAD;
        end
      endcase
    end
  end

  // Key sequencer storage
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q <= KEY_LOCKED;
    end else begin
      key_q <= key_d;
    end
  end

  // Operation engine next state
  always_comb begin
    op_d = op_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    wdata_d = wdata_q;
    old_d = old_q;
    prog_d = 1'b0;
    erase_d = 1'b0;
    err_d = attempt && !mon_ok;
    unique case (op_q)
      OP_IDLE: begin
        if (start && ee_q) begin
          // Whole page: the low address bits are irrelevant
          addr_d = {eff_addr[16:FPEG_PAGE_BITS], FPEG_PAGE_BITS'(0)};
          wdata_d = FPEG_ERASED;
          erase_d = 1'b1;
          cnt_d = ER_CNT;
          op_d = OP_ERASE;
        end else if (start) begin
          // Address goes out first so the old byte can be read back
          addr_d = eff_addr;
          data_d = xwr.data;
          op_d = OP_FETCH;
        end
      end
      OP_FETCH: begin
        old_d = flash_rdata;
        wdata_d = flash_rdata & data_q;
        prog_d = 1'b1;
        cnt_d = WR_CNT;
        op_d = OP_PROG;
      end
      OP_PROG, OP_ERASE: begin
        if (cnt_q == 20'h0_0000) begin
          op_d = OP_IDLE;
        end else begin
          cnt_d = cnt_q - 20'h0_0001;
        end
      end
    endcase
  end

  // Operation engine storage
  always_ff @(posedge clk) begin
    if (rst) begin
      op_q <= OP_IDLE;
      cnt_q <= 20'h0_0000;
      addr_q <= 17'h0_0000;
      data_q <= 8'h00;
      wdata_q <= FPEG_ERASED;
      old_q <= FPEG_ERASED;
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      op_q <= op_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      wdata_q <= wdata_d;
      old_q <= old_d;
      prog_q <= prog_d;
      erase_q <= erase_d;
      err_q <= err_d;
    end
  end

  // Register read data, one cycle after the read strobe
  always_comb begin
    rdata_d = 8'h00;
    if (sfr.rd) begin
      unique case (sfr.addr)
        FPEG_CTRL_OFS: rdata_d = {6'h00, ee_q, we_q};
        FPEG_BANK_OFS: rdata_d = {6'h00, bank_q};
        FPEG_TIME_OFS: rdata_d = {1'b0, bypass_q, 6'h00};
        FPEG_KEY_OFS: rdata_d = {6'h00, key_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data storage
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign sfr_rdata = rdata_q;
  assign flash_prog = prog_q;
  assign flash_erase = erase_q;
  assign flash_addr = addr_q;
  assign flash_wdata = wdata_q;
  assign flash_err_rst = err_q;
  assign oneshot_bypass = bypass_q;
  // The accepting write itself stalls, then every busy cycle
  assign cpu_stall = start || (op_q != OP_IDLE);

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_lockout_sticky: assert property (
    key_q == KEY_DEAD |=> key_q == KEY_DEAD)
    else $error("lockout left without reset");

  chk_bad_first_key: assert property (
    key_wr && !attempt && key_q == KEY_LOCKED && sfr.wdata != FPEG_KEY1
    |=> key_q == KEY_DEAD)
    else $error("wrong first key not locked out");

  chk_early_attempt: assert property (
    attempt && mon_ok && key_q != KEY_OPEN |=> key_q == KEY_DEAD && op_q == OP_IDLE)
    else $error("unkeyed attempt not locked out");

  chk_relock_after: assert property (
    start |=> key_q == KEY_LOCKED)
    else $error("lock not re-engaged after operation");

  chk_monitor_reset: assert property (
    attempt && !mon_ok |=> flash_err_rst && !flash_prog && !flash_erase)
    else $error("missing flash-error reset");

  chk_only_clears: assert property (
    flash_prog |-> (flash_wdata & ~flash_rdata) == 8'h00 && flash_rdata == old_q)
    else $error("program would set a bit");

  chk_stall_write: assert property (
    start && !ee_q |=> cpu_stall [*8])
    else $error("core not stalled during write");

  // Age of the write phase, too long for a delay range in a property
  logic [19:0] wr_age_q, wr_age_d;
  // Age counts up while programming and restarts at every other state
  always_comb begin
    wr_age_d = (op_q == OP_PROG) ? wr_age_q + 20'h0_0001 : 20'h0_0000;
  end
  // Age storage
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_age_q <= 20'h0_0000;
    end else begin
      wr_age_q <= wr_age_d;
    end
  end

  chk_write_length: assert property (
    op_q == OP_PROG && wr_age_q == WR_CNT |=> op_q == OP_IDLE)
    else $error("write did not finish in time");

  chk_erase_page: assert property (
    flash_erase |-> flash_wdata == FPEG_ERASED && flash_addr[9:0] == 10'h000)
    else $error("erase not page aligned");

  chk_enable_kept: assert property (
    flash_prog && !(sfr.wr && sfr.addr == FPEG_CTRL_OFS) |=> we_q)
    else $error("write enable dropped by operation");

  chk_bypass_follow: assert property (
    sfr.wr && sfr.addr == FPEG_TIME_OFS |=> oneshot_bypass == $past(sfr.wdata[6]))
    else $error("bypass did not follow write");

endmodule // fpeg_guard

// ==== fpeg_flash_model.sv ====
// Flash array model: asynchronous read, program clears bits, erase fills a page
`timescale 1ns/10ps
module fpeg_flash_model (
  input wire logic clk,
  input wire logic prog,
  input wire logic erase,
  input wire logic [16:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:131071]; // Whole array, starts erased
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Read follows the presented address with no clock
  assign rdata = mem[addr];
  // Program only pulls bits low; erase sets a whole page
  always @(posedge clk) begin
    if (prog) mem[addr] <= mem[addr] & wdata;
    else if (erase) for (int i = 0; i < 1024; i++) mem[{addr[16:10], 10'(i)}] <= 8'hFF;
  end
endmodule // fpeg_flash_model

// ==== fpeg_guard_tb.sv ====
// Self-checking testbench for the flash program/erase guard
`timescale 1ns/10ps
module fpeg_guard_tb;
  import fpeg_pkg::*;
  logic clk, rst, vdd_mon_on, vdd_mon_reset_src, rd_q;
  fpeg_sfr_type sfr;
  fpeg_xwr_type xwr;
  logic [7:0] sfr_rdata, flash_rdata, flash_wdata, d1, d2;
  logic [16:0] flash_addr;
  logic flash_prog, flash_erase, cpu_stall, flash_err_rst, oneshot_bypass;
  logic [27:0] exq [$]; // Expected results: kind, address, data
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h4675_b606;
  localparam int ER_CYC = 50; // Shortened erase time for simulation
  fpeg_guard #(.ERASE_CYCLES(ER_CYC)) fpeg_guard_i (.clk(clk), .rst(rst), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .xwr(xwr), .vdd_mon_on(vdd_mon_on),
    .vdd_mon_reset_src(vdd_mon_reset_src), .flash_rdata(flash_rdata),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .cpu_stall(cpu_stall), .flash_err_rst(flash_err_rst),
    .oneshot_bypass(oneshot_bypass));
  fpeg_flash_model fpeg_flash_model_i (.clk(clk), .prog(flash_prog), .erase(flash_erase),
    .addr(flash_addr), .wdata(flash_wdata), .rdata(flash_rdata));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare one value and count the outcome
  task automatic chk(input string n, input logic [27:0] s, input logic [27:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Report the counts and end the run
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Register write, one strobe cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) sfr = {2'b10, a, d};
    @(negedge clk) sfr = '0;
  endtask
  // Register read; the monitor compares the answer
  task rd(input logic [7:0] a, input logic [7:0] e);
    exq.push_back({3'd4, 17'h0_0000, e});
    @(negedge clk) sfr = {2'b01, a, 8'h00};
    @(negedge clk) sfr = '0;
  endtask
  // Both key codes in order
  task unlock;
    wr(FPEG_KEY_OFS, FPEG_KEY1);
    wr(FPEG_KEY_OFS, FPEG_KEY2);
  endtask
  // External write; waits out the stall under a bound
  task op(input logic [15:0] a, input logic [7:0] d, input logic [27:0] e, input logic st);
    int n;
    if (e != 28'h0) exq.push_back(e);
    @(negedge clk) xwr = {1'b1, a, d};
    @(negedge clk) xwr = '0;
    chk("stall", {27'h0, cpu_stall}, {27'h0, st});
    n = 0;
    while (cpu_stall !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("busy_len", 28'(n), !st ? 28'h0 : (e[27:25] == 3'd2) ? 28'(ER_CYC) :
      28'(FPEG_WRITE_CYC + 1));
    repeat (2) @(negedge clk);
  endtask
  // Read answers are valid the cycle after the read strobe
  always @(posedge clk) rd_q <= sfr.rd;
  // Every result takes the oldest note off the queue
  always @(negedge clk) begin
    if (!rst && (rd_q || flash_prog || flash_erase || flash_err_rst)) begin
      if (exq.size() == 0) chk("extra", 28'h1, 28'h0);
      else chk("result", rd_q ? {3'd4, 17'h0_0000, sfr_rdata} :
        flash_prog ? {3'd1, flash_addr, flash_wdata} :
        flash_erase ? {3'd2, flash_addr, flash_wdata} : {3'd3, 25'h0}, exq.pop_front());
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test;
    end
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    sfr = '0;
    xwr = '0;
    vdd_mon_on = 1'b1;
    vdd_mon_reset_src = 1'b1;
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(FPEG_CTRL_OFS, 8'h00);
    rd(FPEG_KEY_OFS, 8'h00);
    wr(FPEG_DUMMY_OFS, 8'($random(seed)));
    rd(FPEG_DUMMY_OFS, 8'h00);
    wr(FPEG_TIME_OFS, 8'h40);
    rd(FPEG_TIME_OFS, 8'h40);
    chk("bypass", {27'h0, oneshot_bypass}, 28'h1);
    wr(FPEG_TIME_OFS, 8'h00);
    chk("bypass", {27'h0, oneshot_bypass}, 28'h0);
    wr(FPEG_CTRL_OFS, 8'h01);
    wr(FPEG_KEY_OFS, FPEG_KEY1);
    rd(FPEG_KEY_OFS, 8'h01);
    wr(FPEG_KEY_OFS, FPEG_KEY2);
    rd(FPEG_KEY_OFS, 8'h02);
    op(16'h0523, d1, {3'd1, 17'h0_0523, d1}, 1'b1);
    rd(FPEG_KEY_OFS, 8'h00);
    rd(FPEG_CTRL_OFS, 8'h01);
    unlock;
    op(16'h0523, d2, {3'd1, 17'h0_0523, d1 & d2}, 1'b1);
    wr(FPEG_CTRL_OFS, 8'h03);
    unlock;
    op(16'h07FE, 8'h00, {3'd2, 17'h0_0400, 8'hFF}, 1'b1);
    wr(FPEG_CTRL_OFS, 8'h01);
    unlock;
    op(16'h0523, d2, {3'd1, 17'h0_0523, d2}, 1'b1);
    wr(FPEG_BANK_OFS, 8'h02);
    unlock;
    op(16'h8010, d1, {3'd1, 17'h1_0010, d1}, 1'b1);
    unlock;
    vdd_mon_reset_src = 1'b0;
    op(16'h0010, d1, {3'd3, 25'h0}, 1'b0);
    vdd_mon_reset_src = 1'b1;
    wr(FPEG_KEY_OFS, 8'h12);
    rd(FPEG_KEY_OFS, 8'h03);
    unlock;
    op(16'h0010, d1, 28'h0, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(FPEG_CTRL_OFS, 8'h00);
    rd(FPEG_KEY_OFS, 8'h00);
    wr(FPEG_CTRL_OFS, 8'h01);
    op(16'h0010, d1, 28'h0, 1'b0);
    rd(FPEG_KEY_OFS, 8'h03);
    repeat (4) @(negedge clk);
    chk("pending", 28'(exq.size()), 28'h0);
    finish_test;
  end
endmodule // fpeg_guard_tb
